// ==== fcs_pkg.sv ====
// Package for the flash command sequencer: register map, fields, codes.
// Assumes a 32-bit APB slave with word addresses from the printed offsets.
package fcs_pkg;

  // ----------------------------------------------------------------
  // Register indexes (printed offsets are not word aligned)
  // ----------------------------------------------------------------
  localparam logic [23:0] FCS_IDX_EXTRA_CMD   = 24'h7fc0b7;
  localparam logic [23:0] FCS_IDX_AREA_SEL    = 24'h7fff81;
  localparam logic [23:0] FCS_IDX_CMD_CTRL    = 24'h7fff85;
  localparam logic [23:0] FCS_IDX_LOCAL_RST   = 24'h7fff89;
  // Own registers for the remaining fields and status
  localparam logic [23:0] FCS_IDX_START_HI    = 24'h7fff90;
  localparam logic [23:0] FCS_IDX_START_LO    = 24'h7fff91;
  localparam logic [23:0] FCS_IDX_END_HI      = 24'h7fff92;
  localparam logic [23:0] FCS_IDX_END_LO      = 24'h7fff93;
  localparam logic [23:0] FCS_IDX_WBUF_HI     = 24'h7fff94;
  localparam logic [23:0] FCS_IDX_WBUF_LO     = 24'h7fff95;
  localparam logic [23:0] FCS_IDX_RBUF_HI     = 24'h7fff96;
  localparam logic [23:0] FCS_IDX_RBUF_LO     = 24'h7fff97;
  localparam logic [23:0] FCS_IDX_STATUS      = 24'h7fff98;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCS_RESET_BIT   = 0;
  localparam int FCS_AREA_BIT    = 0;
  localparam int FCS_DONE_BIT    = 4;
  localparam int FCS_STOP_BIT    = 6;
  localparam int FCS_RUN_BIT     = 7;
  // Status register positions
  localparam int FCS_ST_ERASE    = 0;
  localparam int FCS_ST_PROG     = 1;
  localparam int FCS_ST_BLANK    = 3;
  localparam int FCS_ST_ILLEGAL  = 4;
  localparam int FCS_ST_XILLEGAL = 5;
  localparam int FCS_ST_READY    = 8;
  localparam int FCS_ST_XREADY   = 9;

  // ----------------------------------------------------------------
  // Command codes, reset values, boot codes, address step and block mask
  // ----------------------------------------------------------------
  localparam logic [3:0]  FCS_CMD_PROGRAM = 4'h1;
  localparam logic [3:0]  FCS_CMD_BLANK   = 4'h3;
  localparam logic [3:0]  FCS_CMD_ERASE   = 4'h4;
  localparam logic [3:0]  FCS_CMD_UID     = 4'h5;
  localparam logic [2:0]  FCS_XCMD_BOOT   = 3'h1;
  localparam logic [2:0]  FCS_XCMD_WINDOW = 3'h2;
  localparam logic [7:0]  FCS_RST_BYTE    = 8'h00;
  localparam logic [15:0] FCS_RST_HALF    = 16'h0000;
  localparam logic [15:0] FCS_BOOT_DEF    = 16'hffff;
  localparam logic [15:0] FCS_BOOT_ALT    = 16'hfeff;
  localparam logic [19:0] FCS_ADDR_STEP   = 20'h00004;
  localparam logic [19:0] FCS_BLOCK_MASK  = 20'hffc00;

  // Sequencer states
  typedef enum logic [2:0] {
    FCS_IDLE, FCS_BUSY, FCS_UID_HOLD, FCS_DONE
  } fcs_state_t;

endpackage : fcs_pkg

// ==== fcs_flash_engine.sv ====
// Flash array stand-in driven by the sequencer: word store with a busy delay.
// Assumes one request at a time from the sequencer on the same clock.
`timescale 1ns/1ps
module fcs_flash_engine
  import fcs_pkg::*;
#(
  parameter int DEPTH = 64,             // Words held in the array model
  parameter int BUSY  = 4               // Wait cycles per word; a word step takes BUSY+1 cycles
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Operation request
  input  wire logic        op_go,       // One-cycle start pulse
  input  wire logic [3:0]  op_cmd,
  input  wire logic [19:0] op_addr,
  input  wire logic [19:0] op_end,
  input  wire logic [31:0] op_wdata,
  input  wire logic        op_abort,
  // Result
  output logic             op_done,     // One-cycle completion pulse
  output logic [31:0]      op_rdata,
  output logic             op_blank_err
);

  localparam int AW = $clog2(DEPTH);
  // Byte size of one erase block, from the block address mask
  localparam logic [19:0] BLK_STEP = ~FCS_BLOCK_MASK + 20'h00001;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] mem_reg [DEPTH];        // Word array, erased value ones
  logic [19:0] cur_reg, cur_next;      // Walking address
  logic [7:0]  wait_reg, wait_next;    // Per-word delay
  logic        act_reg, act_next;
  logic        done_reg, done_next;     // Completion pulse
  logic        berr_reg, berr_next;
  logic [31:0] rd_reg, rd_next;
  logic [AW-1:0] idx;

  assign idx = cur_reg[AW+1:2];
  assign op_done = done_reg;
  assign op_rdata = rd_reg;
  assign op_blank_err = berr_reg;

  // Next state: walk one word (one block for erase) per delay, ranged commands stop at end
  always_comb begin
    cur_next  = cur_reg;
    wait_next = wait_reg;
    act_next  = act_reg;
    done_next = 1'b0;
    berr_next = berr_reg;
    rd_next   = rd_reg;
    if (op_go) begin
      act_next  = 1'b1;
      wait_next = 8'(BUSY);
      berr_next = 1'b0;
      cur_next  = (op_cmd == FCS_CMD_ERASE) ? (op_addr & FCS_BLOCK_MASK)
                                            : op_addr;
    end else if (act_reg && op_abort) begin
      act_next  = 1'b0;                 // Forced stop ends at once
      done_next = 1'b1;
    end else if (act_reg && wait_reg != 8'h00) begin
      wait_next = wait_reg - 8'h01;
    end else if (act_reg) begin
      if (op_cmd == FCS_CMD_BLANK && mem_reg[idx] != '1)
        berr_next = 1'b1;
      if (op_cmd == FCS_CMD_UID)
        rd_next = mem_reg[idx];
      if (op_cmd == FCS_CMD_BLANK && cur_reg < op_end && !berr_next) begin
        cur_next  = cur_reg + FCS_ADDR_STEP;
        wait_next = 8'(BUSY);
      end else if (op_cmd == FCS_CMD_ERASE &&
                   cur_reg < (op_end & FCS_BLOCK_MASK)) begin
        cur_next  = cur_reg + BLK_STEP;   // Next whole block
        wait_next = 8'(BUSY);
      end else begin
        act_next  = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // Registers; array writes happen on the final step of a word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg  <= 20'h00000;
      wait_reg <= 8'h00;
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
      berr_reg <= 1'b0;
      rd_reg   <= 32'h00000000;
    end else begin
      cur_reg  <= cur_next;
      wait_reg <= wait_next;
      act_reg  <= act_next;
      done_reg <= done_next;
      berr_reg <= berr_next;
      rd_reg   <= rd_next;
    end
  end

  // Array contents carry no reset, like real flash
  always_ff @(posedge pclk) begin
    if (act_reg && !op_abort && wait_reg == 8'h00) begin
      if (op_cmd == FCS_CMD_PROGRAM)
        mem_reg[idx] <= mem_reg[idx] & op_wdata;
      else if (op_cmd == FCS_CMD_ERASE) begin
        // Model is smaller than a block, so a block erase clears all
        for (int i = 0; i < DEPTH; i++)
          mem_reg[i] <= '1;
      end
    end
  end

endmodule : fcs_flash_engine

// ==== fcs_sequencer.sv ====
// Flash command sequencer: APB register file and command control.
// Assumes mode inputs come from logic on pclk; APB master is well behaved.
`timescale 1ns/1ps
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int DEPTH = 64,             // Array words in the engine
  parameter int BUSY  = 4               // Wait cycles per word; a word step takes BUSY+1 cycles
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [25:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Mode qualifiers from the flash mode logic
  input  wire logic        pe_mode,     // ROM program/erase mode
  input  wire logic        pe_enable,   // ROM may be programmed/erased
  // Window and start-up outputs
  output logic [9:0]       window_start,
  output logic [9:0]       window_end,
  output logic             window_all,  // Whole array open
  output logic             boot_alt     // Alternate start-up area
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        rst_bit_reg,  rst_bit_next;   // Local reset bit
  logic        area_reg,     area_next;      // Area select bit
  logic [7:0]  cmd_reg,      cmd_next;       // Command control
  logic [7:0]  xcmd_reg,     xcmd_next;      // Extra-area control
  logic [15:0] sah_reg, sah_next, sal_reg, sal_next;
  logic [15:0] eah_reg, eah_next, eal_reg, eal_next;
  logic [15:0] wbh_reg, wbh_next, wbl_reg, wbl_next;
  logic [15:0] rbh_reg, rbh_next, rbl_reg, rbl_next;
  logic [5:0]  err_reg,      err_next;       // Status error flags
  logic        rdy_reg,      rdy_next;       // Ready flag
  logic        xrdy_reg,     xrdy_next;      // Extra-ready flag
  logic [19:0] uid_addr_reg, uid_addr_next;  // Internal read address
  logic [9:0]  ws_reg, ws_next, we_reg, we_next;
  logic        boot_reg,     boot_next;
  fcs_state_t  st_reg,       st_next;
  logic [31:0] rdata_reg,    rdata_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        wr_en, rd_en, busy, xbusy, wr_ok, cmd_ok, fresh;
  logic [23:0] idx;
  logic [19:0] start_addr, end_addr;
  logic        go, abort, done, blank_err, run, xrun;
  logic [31:0] eng_rdata;

  assign idx        = paddr[25:2];          // Index is word address
  assign wr_en      = psel && penable && pwrite && pstrb[0];
  assign rd_en      = psel && !penable && !pwrite;  // Setup cycle
  assign pready     = 1'b1;                 // Zero wait states
  assign pslverr    = 1'b0;
  assign prdata     = rdata_reg;
  assign busy       = (st_reg == FCS_BUSY);
  assign xbusy      = xrun && !xrdy_reg;
  assign run        = cmd_reg[FCS_RUN_BIT];
  assign xrun       = xcmd_reg[FCS_RUN_BIT];
  assign wr_ok      = pe_mode && !rst_bit_reg;
  assign cmd_ok     = wr_ok && pe_enable;
  assign start_addr = {sah_reg[3:0], sal_reg};
  assign end_addr   = {eah_reg[3:0], eal_reg};
  assign window_start = ws_reg;
  assign window_end   = we_reg;
  assign window_all   = (ws_reg == we_reg);
  assign boot_alt     = boot_reg;

  // Legal user command decode
  function automatic logic legal_cmd(input logic [3:0] c);
    legal_cmd = (c == FCS_CMD_PROGRAM) || (c == FCS_CMD_BLANK) ||
                (c == FCS_CMD_ERASE)   || (c == FCS_CMD_UID);
  endfunction : legal_cmd

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  fcs_flash_engine #(
    .DEPTH (DEPTH),
    .BUSY  (BUSY)
  ) u_engine (
    .pclk         (pclk),
    .presetn      (presetn),
    .op_go        (go),
    .op_cmd       (cmd_reg[3:0]),
    .op_addr      (st_reg == FCS_UID_HOLD ? uid_addr_next : start_addr),
    .op_end       (end_addr),
    .op_wdata     ({wbh_reg, wbl_reg}),
    .op_abort     (abort),
    .op_done      (done),
    .op_rdata     (eng_rdata),
    .op_blank_err (blank_err)
  );

  // ----------------------------------------------------------------
  // Register writes and sequencer
  // ----------------------------------------------------------------
  // One next-state block: bus writes, then hardware updates
  always_comb begin
    rst_bit_next  = rst_bit_reg;
    area_next     = area_reg;
    cmd_next      = cmd_reg;
    xcmd_next     = xcmd_reg;
    sah_next = sah_reg;  sal_next = sal_reg;
    eah_next = eah_reg;  eal_next = eal_reg;
    wbh_next = wbh_reg;  wbl_next = wbl_reg;
    rbh_next = rbh_reg;  rbl_next = rbl_reg;
    err_next      = err_reg;
    rdy_next      = rdy_reg;
    xrdy_next     = xrdy_reg;
    uid_addr_next = uid_addr_reg;
    ws_next = ws_reg;  we_next = we_reg;
    boot_next     = boot_reg;
    st_next       = st_reg;
    go            = 1'b0;
    abort         = 1'b0;
    fresh         = 1'b0;
    // Register writes
    if (wr_en) begin
      case (idx)
        FCS_IDX_LOCAL_RST: rst_bit_next = pwdata[FCS_RESET_BIT];
        FCS_IDX_AREA_SEL:
          if (wr_ok) area_next = pwdata[FCS_AREA_BIT];
        FCS_IDX_CMD_CTRL:
          if (cmd_ok) cmd_next = pwdata[7:0] & 8'hdf;
        FCS_IDX_EXTRA_CMD:
          if (cmd_ok && !(xbusy && pwdata[FCS_RUN_BIT]))
            xcmd_next = pwdata[7:0] & 8'h87;
        FCS_IDX_START_HI: if (wr_ok) sah_next = {12'h000, pwdata[3:0]};
        FCS_IDX_START_LO: if (wr_ok) sal_next = pwdata[15:0];
        FCS_IDX_END_HI:   if (wr_ok) eah_next = {12'h000, pwdata[3:0]};
        FCS_IDX_END_LO:   if (wr_ok) eal_next = pwdata[15:0];
        FCS_IDX_WBUF_HI:  if (wr_ok) wbh_next = pwdata[15:0];
        FCS_IDX_WBUF_LO:  if (wr_ok) wbl_next = pwdata[15:0];
        default: ;
      endcase
    end
    // Local reset clears the set; control spared while busy
    if (rst_bit_next) begin
      area_next = 1'b0;
      sah_next = FCS_RST_HALF;  sal_next = FCS_RST_HALF;
      eah_next = FCS_RST_HALF;  eal_next = FCS_RST_HALF;
      wbh_next = FCS_RST_HALF;  wbl_next = FCS_RST_HALF;
      if (!busy && !xbusy) begin
        cmd_next  = FCS_RST_BYTE;
        xcmd_next = FCS_RST_BYTE;
      end
    end
    // Forced stop of blank check or erase
    if (busy && cmd_reg[FCS_STOP_BIT] &&
        (cmd_reg[3:0] == FCS_CMD_BLANK ||
         cmd_reg[3:0] == FCS_CMD_ERASE))
      abort = 1'b1;
    // User command sequencer
    case (st_reg)
      FCS_IDLE: begin
        if (run) begin
          fresh    = 1'b1;
          err_next = 6'h00;
          if (!legal_cmd(cmd_reg[3:0]) ||
              area_reg != (cmd_reg[3:0] == FCS_CMD_UID)) begin
            err_next[FCS_ST_ILLEGAL] = 1'b1;
            rdy_next = 1'b1;
            st_next  = FCS_DONE;
          end else begin
            go            = 1'b1;
            uid_addr_next = start_addr;
            st_next       = FCS_BUSY;
          end
        end
      end
      FCS_BUSY: begin
        if (done) begin
          if (cmd_reg[3:0] == FCS_CMD_UID) begin
            rbh_next = eng_rdata[31:16];
            rbl_next = eng_rdata[15:0];
          end
          if (blank_err && !abort)
            err_next[FCS_ST_BLANK] = 1'b1;
          rdy_next = 1'b1;
          st_next  = FCS_DONE;
        end
      end
      FCS_DONE: begin
        if (!run) begin
          rdy_next = 1'b0;
          st_next  = (cmd_reg[3:0] == FCS_CMD_UID &&
                      !cmd_reg[FCS_DONE_BIT]) ? FCS_UID_HOLD : FCS_IDLE;
        end
      end
      FCS_UID_HOLD: begin
        if (run) begin
          if (cmd_reg[3:0] != FCS_CMD_UID) begin
            st_next  = FCS_IDLE;          // Other command starts from idle
          end else if (cmd_reg[FCS_DONE_BIT]) begin
            rdy_next = 1'b1;
            st_next  = FCS_DONE;
          end else begin
            uid_addr_next = uid_addr_reg + FCS_ADDR_STEP;
            go            = 1'b1;
            st_next       = FCS_BUSY;
          end
        end
      end
      default: st_next = FCS_IDLE;
    endcase
    // Extra-area commands finish in one step
    if (xrun && !xrdy_reg && !fresh) begin
      err_next = 6'h00;
      if (!area_reg) begin
        err_next[FCS_ST_XILLEGAL] = 1'b1;
      end else if (xcmd_reg[2:0] == FCS_XCMD_BOOT) begin
        if (wbh_reg == FCS_BOOT_DEF && wbl_reg == FCS_BOOT_DEF)
          boot_next = 1'b0;
        else if (wbh_reg == FCS_BOOT_DEF && wbl_reg == FCS_BOOT_ALT)
          boot_next = 1'b1;
        else
          err_next[FCS_ST_XILLEGAL] = 1'b1;
      end else if (xcmd_reg[2:0] == FCS_XCMD_WINDOW &&
                   wbl_reg[9:0] <= wbh_reg[9:0]) begin
        ws_next = wbl_reg[9:0];
        we_next = wbh_reg[9:0];
      end else begin
        err_next[FCS_ST_XILLEGAL] = 1'b1;
      end
      xrdy_next = 1'b1;
    end else if (!xrun) begin
      xrdy_next = 1'b0;
    end
  end

  // Read mux; undefined fields read as zero, last data held otherwise
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en) begin
      case (idx)
        FCS_IDX_LOCAL_RST: rdata_next = {31'h0, rst_bit_reg};
        FCS_IDX_AREA_SEL:  rdata_next = {31'h0, area_reg};
        FCS_IDX_CMD_CTRL:  rdata_next = {24'h0, cmd_reg};
        FCS_IDX_EXTRA_CMD: rdata_next = {24'h0, xcmd_reg};
        FCS_IDX_START_HI:  rdata_next = {16'h0, sah_reg};
        FCS_IDX_START_LO:  rdata_next = {16'h0, sal_reg};
        FCS_IDX_END_HI:    rdata_next = {16'h0, eah_reg};
        FCS_IDX_END_LO:    rdata_next = {16'h0, eal_reg};
        FCS_IDX_WBUF_HI:   rdata_next = {16'h0, wbh_reg};
        FCS_IDX_WBUF_LO:   rdata_next = {16'h0, wbl_reg};
        FCS_IDX_RBUF_HI:   rdata_next = {16'h0, rbh_reg};
        FCS_IDX_RBUF_LO:   rdata_next = {16'h0, rbl_reg};
        FCS_IDX_STATUS:
          rdata_next = {22'h0, xrdy_reg, rdy_reg, 2'b00, err_reg};
        default:           rdata_next = 32'h00000000;
      endcase
    end
  end

  // prdata loads at the setup edge, so it stands through the access cycle
  logic [31:0] rd_setup;
  assign rd_setup = rdata_next;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_bit_reg  <= 1'b0;
      area_reg     <= 1'b0;
      cmd_reg      <= FCS_RST_BYTE;
      xcmd_reg     <= FCS_RST_BYTE;
      sah_reg <= FCS_RST_HALF;  sal_reg <= FCS_RST_HALF;
      eah_reg <= FCS_RST_HALF;  eal_reg <= FCS_RST_HALF;
      wbh_reg <= FCS_RST_HALF;  wbl_reg <= FCS_RST_HALF;
      rbh_reg <= FCS_RST_HALF;  rbl_reg <= FCS_RST_HALF;
      err_reg      <= 6'h00;
      rdy_reg      <= 1'b0;
      xrdy_reg     <= 1'b0;
      uid_addr_reg <= 20'h00000;
      ws_reg       <= 10'h000;
      we_reg       <= 10'h000;
      boot_reg     <= 1'b0;
      st_reg       <= FCS_IDLE;
      rdata_reg    <= 32'h00000000;
    end else begin
      rst_bit_reg  <= rst_bit_next;
      area_reg     <= area_next;
      cmd_reg      <= cmd_next;
      xcmd_reg     <= xcmd_next;
      sah_reg <= sah_next;  sal_reg <= sal_next;
      eah_reg <= eah_next;  eal_reg <= eal_next;
      wbh_reg <= wbh_next;  wbl_reg <= wbl_next;
      rbh_reg <= rbh_next;  rbl_reg <= rbl_next;
      err_reg      <= err_next;
      rdy_reg      <= rdy_next;
      xrdy_reg     <= xrdy_next;
      uid_addr_reg <= uid_addr_next;
      ws_reg       <= ws_next;
      we_reg       <= we_next;
      boot_reg     <= boot_next;
      st_reg       <= st_next;
      rdata_reg    <= rd_setup;
    end
  end

endmodule : fcs_sequencer

// ==== fcs_seq_chk.sv ====
// Checker for the sequencer: port relations over time.
// Assumes a bind onto fcs_sequencer, one clock domain.
`timescale 1ns/1ps
module fcs_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB and mode inputs
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pe_mode,
  input wire logic        pe_enable,
  // Outputs watched
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [9:0]  window_start,
  input wire logic [9:0]  window_end,
  input wire logic        window_all,
  input wire logic        boot_alt
);
  logic [2:0] age_reg;  // Edges since a write that modes allow
  logic [2:0] age_next;
  // Saturates, so a stale write cannot excuse a late change
  always_comb begin
    age_next = (age_reg == 3'h7) ? 3'h7 : age_reg + 3'h1;
    if (psel && penable && pwrite && pe_mode && pe_enable) age_next = 3'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_reg <= 3'h7;
    else age_reg <= age_next;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_ok_a: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  no_slverr_a: assert property (!pslverr)
    else $error("pslverr raised");
  reset_zero_a: assert property ($rose(presetn) |->
    !boot_alt && window_start == 10'h000 && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  rdata_src_a: assert property ($changed(prdata) |->
    $past(psel && !penable && !pwrite)) else $error("prdata moved");
  win_all_a: assert property (window_all ==
    (window_start == window_end)) else $error("window_all wrong");
  start_src_a: assert property ($changed(window_start) |->
    age_reg != 3'h7) else $error("window_start moved unasked");
  end_src_a: assert property ($changed(window_end) |->
    age_reg != 3'h7) else $error("window_end moved unasked");
  boot_src_a: assert property ($changed(boot_alt) |->
    age_reg != 3'h7) else $error("boot_alt moved unasked");
endmodule : fcs_chk

// ==== fcs_sequencer_test.sv ====
// Testbench for the sequencer: APB master, queue checked monitor.
// Assumes prdata stands in the access cycle; the master waits on pready.
`timescale 1ns/1ps
module fcs_sequencer_test;
  import fcs_pkg::*;
  typedef struct {string n; logic [31:0] v; logic [31:0] m;} fcs_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pe_mode = 1'b0, pe_enable = 1'b0;
  logic pready, pslverr, window_all, boot_alt;
  logic [25:0] paddr = 26'h0;
  logic [31:0] pwdata = 32'h0, prdata, rv, seed = 32'h57, d;
  logic [3:0]  pstrb = 4'hf;
  logic [9:0]  window_start, window_end;
  int          err_total = 0, compares = 0;
  fcs_exp_t    exp_q[$], e;
  always #50 pclk = ~pclk;
  fcs_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .pe_mode, .pe_enable,
    .window_start, .window_end, .window_all, .boot_alt);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : check
  // One APB transfer; read data taken at the edge that sees pready high
  task automatic apb(logic [23:0] idx, logic w, logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(logic [23:0] idx, logic [31:0] wd);
    apb(idx, 1'b1, wd);
  endtask : wr
  task automatic chk(string n, logic [23:0] idx, logic [31:0] x,
                     logic [31:0] m);
    exp_q.push_back('{n, x, m});
    apb(idx, 1'b0, 32'h0);
  endtask : chk
  // Start, poll ready under a bound, clear run, expect ready low
  task automatic cmd(logic [23:0] idx, logic [7:0] c, int b);
    wr(idx, {24'h0, c | 8'h80});
    rv = 32'h0;
    for (int k = 0; k < 40 && rv[b] !== 1'b1; k++)
      apb(FCS_IDX_STATUS, 1'b0, 32'h0);
    check("ready up", {31'h0, rv[b]}, 32'h1);
    wr(idx, {24'h0, c});
    chk("ready", FCS_IDX_STATUS, 32'h0, 32'h1 << b);
  endtask : cmd
  // Monitor: each checked read is matched with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 &&
        exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(e.n, prdata & e.m, e.v);
    end
  end
  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #1_000_000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ctrl", FCS_IDX_CMD_CTRL, 32'h0, 32'hff);
    chk("void", 24'h000010, 32'h0, 32'hffffffff);
    wr(FCS_IDX_AREA_SEL, 32'h1);
    chk("area", FCS_IDX_AREA_SEL, 32'h0, 32'hff);
    pe_mode <= 1'b1;
    wr(FCS_IDX_AREA_SEL, 32'h1);
    wr(FCS_IDX_START_LO, 32'h10);
    wr(FCS_IDX_CMD_CTRL, 32'h1);
    chk("area", FCS_IDX_AREA_SEL, 32'h1, 32'hff);
    chk("ctrl", FCS_IDX_CMD_CTRL, 32'h0, 32'hff);
    wr(FCS_IDX_LOCAL_RST, 32'h1);
    chk("start", FCS_IDX_START_LO, 32'h0, 32'hffff);
    wr(FCS_IDX_AREA_SEL, 32'h1);
    chk("area", FCS_IDX_AREA_SEL, 32'h0, 32'hff);
    wr(FCS_IDX_LOCAL_RST, 32'h0);
    $display("test registers done");
    pe_enable <= 1'b1;
    wr(FCS_IDX_END_LO, 32'h1c);
    cmd(FCS_IDX_CMD_CTRL, 8'h04, FCS_ST_READY);
    cmd(FCS_IDX_CMD_CTRL, 8'h03, FCS_ST_READY);
    chk("flags", FCS_IDX_STATUS, 32'h0, 32'h1b);
    d = rnd();
    wr(FCS_IDX_WBUF_HI, {16'h0, d[31:16]});
    wr(FCS_IDX_WBUF_LO, {16'h0, d[15:0] & 16'hfffe});
    wr(FCS_IDX_START_LO, 32'h8);
    cmd(FCS_IDX_CMD_CTRL, 8'h01, FCS_ST_READY);
    wr(FCS_IDX_START_LO, 32'h0);
    cmd(FCS_IDX_CMD_CTRL, 8'h03, FCS_ST_READY);
    chk("blank", FCS_IDX_STATUS, 32'h8, 32'h1b);
    cmd(FCS_IDX_CMD_CTRL, 8'h07, FCS_ST_READY);
    chk("illegal", FCS_IDX_STATUS, 32'h10, 32'h1b);
    cmd(FCS_IDX_CMD_CTRL, 8'h04, FCS_ST_READY);
    cmd(FCS_IDX_CMD_CTRL, 8'h03, FCS_ST_READY);
    chk("flags", FCS_IDX_STATUS, 32'h0, 32'h1b);
    wr(FCS_IDX_END_LO, 32'hfc);
    wr(FCS_IDX_CMD_CTRL, 32'h83);
    wr(FCS_IDX_CMD_CTRL, 32'hc3);
    cmd(FCS_IDX_CMD_CTRL, 8'h43, FCS_ST_READY);
    $display("test user commands done");
    d = rnd();
    wr(FCS_IDX_WBUF_HI, {16'h0, d[31:16]});
    wr(FCS_IDX_WBUF_LO, {16'h0, d[15:0]});
    wr(FCS_IDX_START_LO, 32'h850);
    cmd(FCS_IDX_CMD_CTRL, 8'h01, FCS_ST_READY);
    wr(FCS_IDX_AREA_SEL, 32'h1);
    cmd(FCS_IDX_CMD_CTRL, 8'h05, FCS_ST_READY);
    chk("uid hi", FCS_IDX_RBUF_HI, {16'h0, d[31:16]}, 32'hffff);
    chk("uid lo", FCS_IDX_RBUF_LO, {16'h0, d[15:0]}, 32'hffff);
    cmd(FCS_IDX_CMD_CTRL, 8'h05, FCS_ST_READY);
    chk("uid next", FCS_IDX_RBUF_HI, 32'hffff, 32'hffff);
    cmd(FCS_IDX_CMD_CTRL, 8'h15, FCS_ST_READY);
    chk("uid", FCS_IDX_STATUS, 32'h0, 32'h10);
    wr(FCS_IDX_WBUF_HI, 32'hffff);
    wr(FCS_IDX_WBUF_LO, 32'hfeff);
    cmd(FCS_IDX_EXTRA_CMD, 8'h01, FCS_ST_XREADY);
    check("boot", {31'h0, boot_alt}, 32'h1);
    wr(FCS_IDX_WBUF_LO, 32'h0);
    cmd(FCS_IDX_EXTRA_CMD, 8'h02, FCS_ST_XREADY);
    check("wall", {31'h0, window_all}, 32'h0);
    d = rnd();
    wr(FCS_IDX_WBUF_HI, {16'h0, d[15:0]});
    wr(FCS_IDX_WBUF_LO, {16'h0, d[15:0]});
    cmd(FCS_IDX_EXTRA_CMD, 8'h02, FCS_ST_XREADY);
    check("wall", {31'h0, window_all}, 32'h1);
    cmd(FCS_IDX_EXTRA_CMD, 8'h03, FCS_ST_XREADY);
    chk("xill", FCS_IDX_STATUS, 32'h20, 32'h20);
    $display("test extra area done");
    test_done();
  end
endmodule : fcs_sequencer_test
bind fcs_sequencer fcs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pe_mode, .pe_enable, .pready, .pslverr, .prdata, .window_start,
  .window_end, .window_all, .boot_alt);
